// ---- rtl/asrr_pkg.sv ----
// constants, types and helpers shared by the serial receiver files
package asrr_pkg;

	// ==========================================
	// clock
	localparam int PCLK_PERIOD_NS = 25;         // 40 MHz module clock

	// ==========================================
	// register indices and byte addresses
	localparam int         PADDR_W        = 8;
	localparam logic [7:0] IDX_CTRL_ONE   = 8'h13;
	localparam logic [7:0] IDX_CTRL_TWO   = 8'h14;
	localparam logic [7:0] IDX_CTRL_THREE = 8'h15;
	localparam logic [7:0] IDX_STAT_ONE   = 8'h16;
	localparam logic [7:0] IDX_STAT_TWO   = 8'h17;
	localparam logic [7:0] IDX_DATA_BUF   = 8'h18;
	localparam logic [7:0] IDX_BAUD_SEL   = 8'h19;
	localparam logic [7:0] ADDR_CTRL_ONE   = {IDX_CTRL_ONE[5:0], 2'b00};
	localparam logic [7:0] ADDR_CTRL_TWO   = {IDX_CTRL_TWO[5:0], 2'b00};
	localparam logic [7:0] ADDR_CTRL_THREE = {IDX_CTRL_THREE[5:0], 2'b00};
	localparam logic [7:0] ADDR_STAT_ONE   = {IDX_STAT_ONE[5:0], 2'b00};
	localparam logic [7:0] ADDR_STAT_TWO   = {IDX_STAT_TWO[5:0], 2'b00};
	localparam logic [7:0] ADDR_DATA_BUF   = {IDX_DATA_BUF[5:0], 2'b00};
	localparam logic [7:0] ADDR_BAUD_SEL   = {IDX_BAUD_SEL[5:0], 2'b00};

	// ==========================================
	// field positions, masks and reset values
	localparam int         CTRL1_ENABLE_BIT = 6;
	localparam int         CTRL1_LEN9_BIT   = 4;
	localparam int         CTRL2_RIE_BIT    = 5;
	localparam int         CTRL2_RXEN_BIT   = 2;
	localparam int         CTRL3_NINTH_BIT  = 7;
	localparam logic [7:0] CTRL3_RW_MASK    = 8'h4F;
	localparam logic [7:0] BAUD_RW_MASK     = 8'h37;
	localparam int         STAT1_FULL_BIT   = 5;
	localparam int         STAT1_IDLE_BIT   = 4;
	localparam int         STAT1_OVR_BIT    = 3;
	localparam int         STAT1_NOISE_BIT  = 2;
	localparam int         STAT1_FRAME_BIT  = 1;
	localparam int         STAT2_BREAK_BIT  = 1;
	localparam int         STAT2_BUSY_BIT   = 0;
	localparam logic [7:0] CTRL_RESET       = 8'h00;
	localparam logic [7:0] BAUD_RESET       = 8'h00;

	// ==========================================
	// oversampling timing
	localparam logic [4:0] TICK_FIRST  = 5'd1;
	localparam logic [4:0] TICK_LAST   = 5'd16;
	localparam logic [4:0] TICK_S3     = 5'd3;
	localparam logic [4:0] TICK_S5     = 5'd5;
	localparam logic [4:0] TICK_S7     = 5'd7;
	localparam logic [4:0] TICK_S8     = 5'd8;
	localparam logic [4:0] TICK_S9     = 5'd9;
	localparam logic [4:0] TICK_S10    = 5'd10;
	localparam logic [3:0] DATA_BITS_8 = 4'd8;
	localparam logic [3:0] DATA_BITS_9 = 4'd9;
	localparam logic [7:0] IDLE_BITS_8 = 8'd10;
	localparam logic [7:0] IDLE_BITS_9 = 8'd11;
	localparam int STOP_TICK_8 = 16 * (1 + 8) + 10;   // 154
	localparam int STOP_TICK_9 = 16 * (1 + 9) + 10;   // 170

	// ==========================================
	// types
	typedef enum logic [1:0] {RX_SEARCH, RX_START, RX_DATA, RX_STOP} asrr_state_e;

	typedef struct packed {
		logic level;
		logic noisy;
	} asrr_vote_s;

	typedef struct packed {
		logic [7:0] data;
		logic       ninth;
		logic       noise;
		logic       framing;
		logic       brk;
	} asrr_char_s;

	// data bits per character for the selected length
	function automatic logic [3:0] asrr_data_bits(input logic len9);
		return len9 ? DATA_BITS_9 : DATA_BITS_8;
	endfunction : asrr_data_bits

endpackage : asrr_pkg

// ---- rtl/asrr_tick_gen.sv ----
// oversampling tick divider from the module clock
`timescale 1ns/100ps
module asrr_tick_gen
	import asrr_pkg::*;
(
	input  wire logic       pclk,     // module clock
	input  wire logic       presetn,  // async reset, active low
	input  wire logic       enable,   // divider runs while high
	input  wire logic [7:0] divisor,  // clocks per tick minus one
	output logic            tick      // one-cycle oversampling tick
);

	logic [7:0] count_reg;

	// ==========================================
	// divider counter, restarts whenever disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 8'h00;
			tick      <= 1'b0;
		end else if (!enable) begin
			count_reg <= 8'h00;
			tick      <= 1'b0;
		end else if (count_reg >= divisor) begin
			count_reg <= 8'h00;
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + 8'h01;
			tick      <= 1'b0;
		end
	end

endmodule : asrr_tick_gen

// ---- rtl/asrr_vote.sv ----
// three-sample majority vote with disagreement flag
`timescale 1ns/100ps
module asrr_vote
	import asrr_pkg::*;
(
	input  wire logic samp_a,  // first sample
	input  wire logic samp_b,  // second sample
	input  wire logic samp_c,  // third sample
	output asrr_vote_s vote    // majority and noise
);

	// ==========================================
	// majority of three, noisy unless all equal
	assign vote.level = (samp_a & samp_b) | (samp_a & samp_c) | (samp_b & samp_c);
	assign vote.noisy = (samp_a | samp_b | samp_c) & ~(samp_a & samp_b & samp_c);

endmodule : asrr_vote

// ---- rtl/asrr_receiver.sv ----
// serial receiver with oversampled data recovery and apb registers
// What this block does
// - receive 8 or 9 data bits, selectable
// - ninth bit is bit 8, else bit 7
// - shift line bits into shift register
// - data buffer is read-only from bus
// - whole character loads buffer, sets full
// - full and enable raise receive interrupt
// - sample line at sixteen times baud
// - realign ticks after start and falling data
// - start is zero after three ones
// - ticks 3,5,7 verify start, one gives noise
// - failed start resets ticks, searches again
// - data bit is vote of ticks 8-10
// - start ticks 8-10 ones only set noise
// - stop vote zero is framing, disagreement noise
// - missing stop one, including break, frames
// - framing flag sets together with full
// - realign on valid falling edge inside character
// - stop sampled 154 or 170 ticks after edge
// - overrun keeps old character, drops new
// - break clears buffer, ninth, sets break flag
// - idle after 10 or 11 ones
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module asrr_receiver
	import asrr_pkg::*;
(
	input  wire logic               pclk,     // module clock
	input  wire logic               presetn,  // async reset, active low
	input  wire logic               psel,     // apb select
	input  wire logic               penable,  // apb access phase
	input  wire logic               pwrite,   // apb write
	input  wire logic [PADDR_W-1:0] paddr,    // apb byte address
	input  wire logic [31:0]        pwdata,   // apb write data
	input  wire logic [3:0]         pstrb,    // apb byte strobes
	output logic      [31:0]        prdata,   // apb read data
	output logic                    pready,   // apb ready
	output logic                    pslverr,  // apb error, unmapped
	input  wire logic               rxd,      // serial receive line
	output logic                    rx_irq    // receive interrupt request
);

	// ==========================================
	// registers and state
	logic [7:0]  ctrl_one_reg;
	logic [7:0]  ctrl_two_reg;
	logic [7:0]  ctrl_three_reg;
	logic [7:0]  baud_reg;
	logic [7:0]  data_buf_reg;
	logic        ninth_reg;
	logic        full_reg;
	logic        idle_reg;
	logic        ovr_reg;
	logic        noise_reg;
	logic        frame_reg;
	logic        brk_reg;
	logic        stat1_seen_reg;
	logic        stat2_seen_reg;
	logic        idle_armed_reg;
	logic [7:0]  ones_cnt_reg;
	asrr_state_e state_reg;
	logic [4:0]  tick_cnt_reg;
	logic [3:0]  bit_cnt_reg;
	logic [2:0]  hist_reg;
	logic        samp_a_reg;
	logic        samp_b_reg;
	logic        voted_reg;
	logic        prev_vote_reg;
	logic        edge_seen_reg;
	logic [4:0]  since_edge_reg;
	logic        char_noise_reg;
	logic [8:0]  shift_reg;

	logic        rx_on;
	logic        len9;
	logic        tick;
	asrr_vote_s  vote;
	asrr_char_s  char_in;
	logic        start_edge;
	logic        fall_edge;
	logic        vote_tick;
	logic        bit_end;
	logic        char_done;
	logic        realign;
	logic        acc;
	logic        rd_acc;
	logic        wr_acc;
	logic        addr_hit;
	logic        clr_main;
	logic        clr_brk;
	logic [7:0]  rd_val;

	assign rx_on = ctrl_one_reg[CTRL1_ENABLE_BIT] & ctrl_two_reg[CTRL2_RXEN_BIT];
	assign len9  = ctrl_one_reg[CTRL1_LEN9_BIT];

	// ==========================================
	// submodules: tick divider and sample voter
	asrr_tick_gen u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (rx_on),
		.divisor (baud_reg),
		.tick    (tick)
	);

	asrr_vote u_vote (
		.samp_a (samp_a_reg),
		.samp_b (samp_b_reg),
		.samp_c (rxd),
		.vote   (vote)
	);

	// ==========================================
	// apb decode
	assign acc    = psel & penable;
	assign rd_acc = acc & ~pwrite;
	assign wr_acc = acc & pwrite & pstrb[0];
	assign pready = 1'b1;
	assign addr_hit = (paddr == ADDR_CTRL_ONE) | (paddr == ADDR_CTRL_TWO) |
		(paddr == ADDR_CTRL_THREE) | (paddr == ADDR_STAT_ONE) |
		(paddr == ADDR_STAT_TWO) | (paddr == ADDR_DATA_BUF) |
		(paddr == ADDR_BAUD_SEL);
	assign pslverr = acc & ~addr_hit;

	// read value mux
	always_comb begin
		rd_val = 8'h00;
		unique case (paddr)
			ADDR_CTRL_ONE:   rd_val = ctrl_one_reg;
			ADDR_CTRL_TWO:   rd_val = ctrl_two_reg;
			ADDR_CTRL_THREE: rd_val = {ninth_reg, ctrl_three_reg[6:0]};
			ADDR_STAT_ONE:   rd_val = {2'b00, full_reg, idle_reg, ovr_reg,
				noise_reg, frame_reg, 1'b0};
			ADDR_STAT_TWO:   rd_val = {6'h00, brk_reg, (state_reg != RX_STOP) ?
				(state_reg != RX_SEARCH) : 1'b1};
			ADDR_DATA_BUF:   rd_val = data_buf_reg;
			ADDR_BAUD_SEL:   rd_val = baud_reg;
			default:         rd_val = 8'h00;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, rd_val};
		end
	end

	// writable control registers; status and buffer ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_reg   <= CTRL_RESET;
			ctrl_two_reg   <= CTRL_RESET;
			ctrl_three_reg <= CTRL_RESET;
			baud_reg       <= BAUD_RESET;
		end else if (wr_acc) begin
			if (paddr == ADDR_CTRL_ONE) begin
				ctrl_one_reg <= pwdata[7:0];
			end
			if (paddr == ADDR_CTRL_TWO) begin
				ctrl_two_reg <= pwdata[7:0];
			end
			if (paddr == ADDR_CTRL_THREE) begin
				ctrl_three_reg <= pwdata[7:0] & CTRL3_RW_MASK;
			end
			if (paddr == ADDR_BAUD_SEL) begin
				baud_reg <= pwdata[7:0] & BAUD_RW_MASK;
			end
		end
	end

	// two-step clear: status read arms, buffer read clears
	assign clr_main = rd_acc & (paddr == ADDR_DATA_BUF) & stat1_seen_reg;
	assign clr_brk  = rd_acc & (paddr == ADDR_DATA_BUF) & stat2_seen_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat1_seen_reg <= 1'b0;
			stat2_seen_reg <= 1'b0;
		end else if (rd_acc) begin
			if (paddr == ADDR_STAT_ONE) begin
				stat1_seen_reg <= 1'b1;
			end else if (paddr == ADDR_DATA_BUF) begin
				stat1_seen_reg <= 1'b0;
			end
			if (paddr == ADDR_STAT_TWO) begin
				stat2_seen_reg <= 1'b1;
			end else if (paddr == ADDR_DATA_BUF) begin
				stat2_seen_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// recovery timing terms
	assign start_edge = (state_reg == RX_SEARCH) & tick & (hist_reg == 3'b111) & ~rxd;
	assign fall_edge  = tick & hist_reg[0] & ~rxd;
	assign vote_tick  = tick & (tick_cnt_reg == TICK_S10) & ~voted_reg;
	assign bit_end    = tick & (tick_cnt_reg == TICK_LAST);
	assign char_done  = (state_reg == RX_STOP) & tick & (tick_cnt_reg == TICK_S10);
	// one-to-zero confirmed by consecutive votes, edge kept as new tick 1
	assign realign    = (state_reg == RX_DATA) & vote_tick & prev_vote_reg & ~vote.level &
		edge_seen_reg;

	// line history of the last three tick samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist_reg <= 3'b000;
		end else if (!rx_on) begin
			hist_reg <= 3'b000;
		end else if (tick) begin
			hist_reg <= {hist_reg[1:0], rxd};
		end
	end

	// falling edge tracking since the last vote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_seen_reg  <= 1'b0;
			since_edge_reg <= 5'd0;
		end else if (!rx_on || vote_tick || state_reg == RX_SEARCH) begin
			edge_seen_reg  <= 1'b0;
			since_edge_reg <= 5'd0;
		end else if (fall_edge) begin
			edge_seen_reg  <= 1'b1;
			since_edge_reg <= TICK_FIRST;
		end else if (tick && edge_seen_reg && since_edge_reg != TICK_LAST) begin
			since_edge_reg <= since_edge_reg + 5'd1;
		end
	end

	// tick counter 1..16 within each bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= TICK_FIRST;
		end else if (!rx_on || state_reg == RX_SEARCH) begin
			tick_cnt_reg <= TICK_FIRST;
		end else if (tick) begin
			if (realign) begin
				// edge tick is 1: next tick is count plus two
				tick_cnt_reg <= (since_edge_reg >= TICK_LAST - 5'd1) ? TICK_LAST :
					since_edge_reg + 5'd2;
			end else if (tick_cnt_reg == TICK_LAST) begin
				tick_cnt_reg <= TICK_FIRST;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 5'd1;
			end
		end
	end

	// sample capture at ticks 3/5 and 8/9, vote-once guard per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_a_reg <= 1'b1;
			samp_b_reg <= 1'b1;
			voted_reg  <= 1'b0;
		end else if (!rx_on || state_reg == RX_SEARCH) begin
			samp_a_reg <= 1'b1;
			samp_b_reg <= 1'b1;
			voted_reg  <= 1'b0;
		end else if (tick) begin
			if (tick_cnt_reg == TICK_S3 || tick_cnt_reg == TICK_S8) begin
				samp_a_reg <= rxd;
			end
			if (tick_cnt_reg == TICK_S5 || tick_cnt_reg == TICK_S9) begin
				samp_b_reg <= rxd;
			end
			if (vote_tick) begin
				voted_reg <= 1'b1;
			end else if (bit_end) begin
				voted_reg <= 1'b0;
			end
		end
	end

	// character state machine and shift register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= RX_SEARCH;
			bit_cnt_reg    <= 4'd0;
			shift_reg      <= 9'h000;
			prev_vote_reg  <= 1'b0;
			char_noise_reg <= 1'b0;
		end else if (!rx_on) begin
			state_reg <= RX_SEARCH;
		end else begin
			unique case (state_reg)
				RX_SEARCH: begin
					if (start_edge) begin
						state_reg      <= RX_START;
						bit_cnt_reg    <= 4'd0;
						shift_reg      <= 9'h000;
						char_noise_reg <= 1'b0;
					end
				end
				RX_START: begin
					if (tick && tick_cnt_reg == TICK_S7) begin
						if (vote.level) begin
							state_reg <= RX_SEARCH;
						end else if (vote.noisy) begin
							char_noise_reg <= 1'b1;
						end
					end
					if (vote_tick && (vote.level || vote.noisy)) begin
						char_noise_reg <= 1'b1;
					end
					if (vote_tick) begin
						prev_vote_reg <= 1'b0;
					end
					if (bit_end) begin
						state_reg <= RX_DATA;
					end
				end
				RX_DATA: begin
					if (vote_tick) begin
						shift_reg     <= {vote.level, shift_reg[8:1]};
						prev_vote_reg <= vote.level;
						bit_cnt_reg   <= bit_cnt_reg + 4'd1;
						if (vote.noisy) begin
							char_noise_reg <= 1'b1;
						end
					end
					if (bit_end && bit_cnt_reg == asrr_data_bits(len9)) begin
						state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (char_done) begin
						state_reg <= RX_SEARCH;
					end
				end
			endcase
		end
	end

	// ==========================================
	// finished character, stop vote judged here
	assign char_in.data    = len9 ? shift_reg[7:0] : shift_reg[8:1];
	assign char_in.ninth   = shift_reg[8];
	assign char_in.noise   = char_noise_reg | vote.noisy;
	assign char_in.framing = ~vote.level;
	assign char_in.brk     = ~vote.level & ~(|shift_reg);

	// buffer and receive flags; new events win over clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_buf_reg <= 8'h00;
			ninth_reg    <= 1'b0;
			full_reg     <= 1'b0;
			ovr_reg      <= 1'b0;
			noise_reg    <= 1'b0;
			frame_reg    <= 1'b0;
			brk_reg      <= 1'b0;
		end else begin
			if (clr_main) begin
				full_reg  <= 1'b0;
				ovr_reg   <= 1'b0;
				noise_reg <= 1'b0;
				frame_reg <= 1'b0;
			end
			if (clr_brk) begin
				brk_reg <= 1'b0;
			end
			if (char_done) begin
				if (full_reg && !clr_main) begin
					ovr_reg <= 1'b1;
				end else if (char_in.brk) begin
					data_buf_reg <= 8'h00;
					ninth_reg    <= 1'b0;
					brk_reg      <= 1'b1;
					full_reg     <= 1'b1;
					frame_reg    <= 1'b1;
					noise_reg    <= char_in.noise;
				end else begin
					data_buf_reg <= char_in.data;
					ninth_reg    <= char_in.ninth;
					full_reg     <= 1'b1;
					frame_reg    <= char_in.framing;
					noise_reg    <= char_in.noise;
				end
			end
		end
	end

	// idle detection: counts sampled ones after a character
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ones_cnt_reg   <= 8'h00;
			idle_armed_reg <= 1'b0;
			idle_reg       <= 1'b0;
		end else begin
			if (clr_main) begin
				idle_reg <= 1'b0;
			end
			if (char_done) begin
				idle_armed_reg <= 1'b1;
				ones_cnt_reg   <= 8'h00;
			end else if (!rx_on || state_reg != RX_SEARCH || (tick && !rxd)) begin
				ones_cnt_reg <= 8'h00;
			end else if (tick && idle_armed_reg) begin
				if (ones_cnt_reg == {(len9 ? IDLE_BITS_9[3:0] : IDLE_BITS_8[3:0]), 4'h0}) begin
					idle_reg       <= 1'b1;
					idle_armed_reg <= 1'b0;
				end else begin
					ones_cnt_reg <= ones_cnt_reg + 8'h01;
				end
			end
		end
	end

	// receive interrupt from flag and enable
	assign rx_irq = full_reg & ctrl_two_reg[CTRL2_RIE_BIT];

endmodule : asrr_receiver

// ---- verif/asrr_monitor.sv ----
// port checker for the serial receiver
`timescale 1ns/100ps
module asrr_monitor
	import asrr_pkg::*;
(
	input wire logic               pclk,    // clock
	input wire logic               presetn, // reset, active low
	input wire logic               psel,    // apb select
	input wire logic               penable, // apb enable
	input wire logic               pwrite,  // apb write
	input wire logic [PADDR_W-1:0] paddr,   // apb address
	input wire logic [31:0]        pwdata,  // apb write data
	input wire logic [3:0]         pstrb,   // apb strobes
	input wire logic [31:0]        prdata,  // apb read data
	input wire logic               pready,  // apb ready
	input wire logic               pslverr, // apb error
	input wire logic               rxd,     // serial line
	input wire logic               rx_irq   // receive interrupt
);
	// ==========================================
	// helper state
	logic       acc;      // completed access
	logic       mapped;   // address hits a register
	logic       rie_reg;  // last written interrupt enable
	logic       rxd_reg;  // delayed line
	logic [7:0] fall_reg; // cycles since line fell
	logic [7:0] last_reg; // previous read address

	// access decode
	assign acc    = psel && penable && pready;
	assign mapped = paddr >= ADDR_CTRL_ONE && paddr <= ADDR_BAUD_SEL && paddr[1:0] == 2'b00;

	// shadow of the interrupt enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rie_reg <= 1'b0;
		end else if (acc && pwrite && pstrb[0] && paddr == ADDR_CTRL_TWO) begin
			rie_reg <= pwdata[CTRL2_RIE_BIT];
		end
	end

	// saturating count since the last falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_reg  <= 1'b1;
			fall_reg <= 8'hFF;
		end else begin
			rxd_reg <= rxd;
			if (rxd_reg && !rxd) begin
				fall_reg <= 8'h00;
			end else if (fall_reg != 8'hFF) begin
				fall_reg <= fall_reg + 8'h01;
			end
		end
	end

	// previous read, writes break the clearing pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_reg <= 8'h00;
		end else if (acc) begin
			last_reg <= pwrite ? 8'h00 : paddr;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================
	// properties
	property p_rdy;
		psel && penable |-> pready;
	endproperty
	a_rdy: assert property (p_rdy)
		else $error("access not completed");
	property p_unmap;
		psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped access not refused");
	property p_map;
		psel && penable && mapped |-> !pslverr;
	endproperty
	a_map: assert property (p_map)
		else $error("mapped access refused");
	property p_rdhi;
		acc && !pwrite |-> prdata[31:8] == 24'h0;
	endproperty
	a_rdhi: assert property (p_rdhi)
		else $error("read data upper bits set");
	property p_irqoff;
		!rie_reg |-> !rx_irq;
	endproperty
	a_irqoff: assert property (p_irqoff)
		else $error("interrupt while disabled");
	property p_irqstat;
		acc && !pwrite && paddr == ADDR_STAT_ONE && $past(rx_irq) |-> prdata[STAT1_FULL_BIT];
	endproperty
	a_irqstat: assert property (p_irqstat)
		else $error("interrupt without full flag");
	property p_irqtime;
		$rose(rx_irq) && $past(rie_reg) |-> fall_reg inside {[8'h05:8'hC8]};
	endproperty
	a_irqtime: assert property (p_irqtime)
		else $error("character done at wrong time");
	property p_clr;
		acc && !pwrite && paddr == ADDR_DATA_BUF && last_reg == ADDR_STAT_ONE |=> !rx_irq;
	endproperty
	a_clr: assert property (p_clr)
		else $error("full flag not cleared");

	// main scenarios reached
	c_irq: cover property ($rose(rx_irq));
	c_err: cover property (pslverr);
	c_ovr: cover property (acc && !pwrite && paddr == ADDR_STAT_ONE && prdata[STAT1_OVR_BIT]);
endmodule : asrr_monitor

bind asrr_receiver asrr_monitor u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxd(rxd), .rx_irq(rx_irq)
);

// ---- verif/asrr_tx_model.sv ----
// remote transmitter model driving the serial line
`timescale 1ns/100ps
module asrr_tx_model
	import asrr_pkg::*;
(
	input  wire logic       pclk, // clock
	input  wire logic       go,   // start one frame
	input  wire logic [8:0] chr,  // character, lsb first
	input  wire logic       len9, // nine data bits
	input  wire logic       stop, // stop bit level
	input  wire logic       nz,   // glitch in first data bit
	input  wire logic       rn,   // runt start pulse only
	output logic            rxd,  // serial line, pulled high
	output logic            busy  // frame in progress
);
	logic [10:0] fr; // start, data, stop

	// sixteen clocks per bit at divisor zero; line idles at its pull-up level
	initial begin
		rxd  = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge pclk);
			if (go) begin
				busy <= 1'b1;
				fr = {stop, len9 ? chr[8] : stop, chr[7:0], 1'b0};
				for (int b = 0; b < (rn ? 1 : (len9 ? 11 : 10)); b++) begin
					for (int c = 0; c < 16; c++) begin
						rxd <= rn ? (c > 1) : fr[b] ^ (nz && b == 1 && c == 8);
						@(posedge pclk);
					end
				end
				rxd  <= 1'b1;
				busy <= 1'b0;
			end
		end
	end
endmodule : asrr_tx_model

// ---- verif/test_async_serial_receiver_recovery.sv ----
// self-checking bench for the serial receiver
`timescale 1ns/100ps
module test_async_serial_receiver_recovery
	import asrr_pkg::*;
	;
	logic        pclk, pready, pslverr, rxd, rx_irq, busy;     // design and model outputs
	logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;  // bus control
	logic        pwrite = 1'b0, go = 1'b0, l9 = 1'b0;          // direction and frame start
	logic        stp = 1'b1, nz = 1'b0, rn = 1'b0;             // frame options
	logic [7:0]  paddr = 8'h00;                                // bus address
	logic [31:0] pwdata = 32'h0, prdata;                       // bus data
	logic [8:0]  chr = 9'h000, c, d;                           // characters
	logic [32:0] exp_q[$], msk_q[$];                           // expected bus results
	int          err_count = 0, checked = 0, cyc = 0;          // counters

	// ==========================================
	// clock, design and far side
	initial begin
		pclk = 1'b0;
		forever #(PCLK_PERIOD_NS / 2.0) pclk = ~pclk;
	end
	asrr_receiver u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .rx_irq(rx_irq)
	);
	asrr_tx_model u_tx (
		.pclk(pclk), .go(go), .chr(chr), .len9(l9), .stop(stp), .nz(nz), .rn(rn),
		.rxd(rxd), .busy(busy)
	);

	// ==========================================
	// compare and report
	task automatic cmp_bus(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
		checked++;
		if ((g & m) !== e) begin
			err_count++;
			$display("wrong value at %0t: bus got %h want %h", $time, g & m, e);
		end
	endtask : cmp_bus
	task automatic chk_irq(input logic e);
		checked++;
		if (rx_irq !== e) begin
			err_count++;
			$display("wrong value at %0t: irq got %b want %b", $time, rx_irq, e);
		end
	endtask : chk_irq
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask : fin
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// watcher: every completed access takes the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			cmp_bus({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
		end
	end

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 30000) begin
			err_count++;
			results();
		end
	end

	// ==========================================
	// drivers
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
		exp_q.push_back({!(a >= ADDR_CTRL_ONE && a <= ADDR_BAUD_SEL && a[1:0] == 2'b00),
			24'h0, w ? 8'h00 : v & m});
		msk_q.push_back({1'b1, w ? 32'h0 : {24'hFFFFFF, m}});
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h0, v};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : bus
	task automatic send(input logic [8:0] x, input logic s, input logic n, input logic r);
		chr <= x;
		stp <= s;
		nz  <= n;
		rn  <= r;
		go  <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		do @(posedge pclk); while (busy);
	endtask : send
	// after the line has idled: status, buffer, ninth bit
	task automatic chk(input logic [8:0] x, input logic [7:0] s, input logic [7:0] m,
		input logic n);
		repeat (200) @(posedge pclk);
		bus(1'b0, ADDR_STAT_ONE, s, m);
		bus(1'b0, ADDR_DATA_BUF, x[7:0], 8'hFF);
		bus(1'b0, ADDR_CTRL_THREE, {n, 7'h00}, 8'h80);
	endtask : chk

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(27424));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 7; i++) bus(1'b0, ADDR_CTRL_ONE + 8'(4 * i), 8'h00, 8'hFF);
		bus(1'b0, 8'h00, 8'h00, 8'hFF);
		bus(1'b1, ADDR_DATA_BUF, 8'hA5, 8'hFF);
		bus(1'b0, ADDR_DATA_BUF, 8'h00, 8'hFF);
		bus(1'b1, ADDR_CTRL_THREE, 8'hFF, 8'hFF);
		bus(1'b0, ADDR_CTRL_THREE, CTRL3_RW_MASK, 8'hFF);
		fin("registers");
		bus(1'b1, ADDR_CTRL_ONE, 8'h40, 8'hFF);  // enable, 8-bit
		bus(1'b1, ADDR_CTRL_TWO, 8'h24, 8'hFF);  // receive and interrupt enable
		bus(1'b1, ADDR_BAUD_SEL, 8'h00, 8'hFF);  // tick every clock
		for (int i = 0; i < 3; i++) begin
			c = 9'($urandom) & 9'h0FF;
			send(c, 1'b1, 1'b0, 1'b0);
			chk_irq(1'b1);
			chk(c, 8'h30, 8'hFF, c[7]);
			chk_irq(1'b0);
		end
		fin("eight bit");
		l9 <= 1'b1;
		bus(1'b1, ADDR_CTRL_ONE, 8'h50, 8'hFF);
		for (int i = 0; i < 2; i++) begin
			c = 9'($urandom);
			send(c, 1'b1, 1'b0, 1'b0);
			chk(c, 8'h30, 8'hFF, c[8]);
		end
		l9 <= 1'b0;
		bus(1'b1, ADDR_CTRL_ONE, 8'h40, 8'hFF);
		fin("nine bit");
		c = (9'($urandom) & 9'h0FF) | 9'h001;
		send(c, 1'b0, 1'b0, 1'b0);
		chk(c, 8'h22, 8'h2E, c[7]);
		send(9'h000, 1'b0, 1'b0, 1'b0);
		chk(9'h000, 8'h22, 8'h2E, 1'b0);
		bus(1'b0, ADDR_STAT_TWO, 8'h02, 8'h02);
		fin("framing and break");
		c = 9'($urandom) & 9'h0FC;
		send(c, 1'b1, 1'b1, 1'b0);
		chk(c, 8'h24, 8'h2E, c[7]);
		fin("noise");
		send(9'h000, 1'b1, 1'b0, 1'b1);
		repeat (200) @(posedge pclk);
		chk_irq(1'b0);
		bus(1'b0, ADDR_STAT_ONE, 8'h00, 8'h20);
		c = 9'($urandom) & 9'h0FF;
		send(c, 1'b1, 1'b0, 1'b0);
		chk(c, 8'h20, 8'h2E, c[7]);
		fin("false start");
		c = 9'($urandom) & 9'h0FF;
		d = 9'($urandom) & 9'h0FF;
		send(c, 1'b1, 1'b0, 1'b0);
		send(d, 1'b1, 1'b0, 1'b0);
		chk(c, 8'h28, 8'h2E, c[7]);
		fin("overrun");
		bus(1'b1, ADDR_CTRL_TWO, 8'h04, 8'hFF);
		send(d, 1'b1, 1'b0, 1'b0);
		chk_irq(1'b0);
		bus(1'b1, ADDR_CTRL_TWO, 8'h24, 8'hFF);
		chk_irq(1'b1);
		chk(d, 8'h20, 8'h2E, d[7]);
		fin("interrupt mask");
		results();
	end
endmodule : test_async_serial_receiver_recovery
